// ==== rtl/psm_ctrl.sv ====
// Pin state controller: sets pad buffer controls from the CPU operating state.
// Assumes synchronous inputs; init_b is the external reset pin level.
//
// Function
// RQ1 - Stop with float select: float, clamp input zero
// RQ2 - Maintained output keeps value at mode entry
// RQ3 - Peripheral owner keeps driving, else port latch
// RQ4 - Retained pin keeps its prior direction
// RQ5 - Reset held: float outputs, inputs off, NMI on
// RQ6 - After reset release: float, inputs enabled
// RQ7 - Sleep and plain stop retain prior state
// RQ8 - NMI and interrupt pins stay input enabled
// RQ9 - Register pin state on mode entry
`timescale 1ns/1ns
module psm_ctrl #(
	parameter int                  NPINS    = psm_pkg::PSM_NPINS,
	parameter logic [NPINS-1:0]    WAKE_MSK = '0,
	parameter logic [NPINS-1:0]    NMI_MSK  = '0
) (
	input  wire logic                     clk,
	input  wire logic                     rst_b,
	input  wire logic                     init_b,
	input  wire psm_pkg::psm_mode_t       mode,
	input  wire logic [NPINS-1:0]         periph_own,
	input  wire logic [NPINS-1:0]         periph_out,
	input  wire logic [NPINS-1:0]         periph_oe,
	input  wire logic [NPINS-1:0]         port_out,
	input  wire logic [NPINS-1:0]         port_dir,
	input  wire logic [NPINS-1:0]         pad_in,
	output      psm_pkg::psm_pin_t [NPINS-1:0] pin_ctl,
	output      logic [NPINS-1:0]         core_in,
	output      psm_pkg::psm_state_t      state
);
	import psm_pkg::*;

	psm_state_t state_q;
	psm_state_t state_d;

	// ---------------------------------------------------------------
	// Decode helpers
	// ---------------------------------------------------------------
	// Low-power state chosen from run by a request
	function automatic psm_state_t psm_entry_state(input psm_mode_t m);
		psm_state_t s;
		if (m.stop) begin
			s = m.stop_float_select ? PSM_STOP_FLT : PSM_STOP_KEEP;
		end else if (m.sleep) begin
			s = PSM_SLEEP;
		end else begin
			s = PSM_RUN;
		end
		return s;
	endfunction

	// Request still holds the given low-power state
	function automatic logic psm_still_req(input psm_state_t s, input psm_mode_t m);
		logic r;
		case (s)
			PSM_SLEEP: begin
				r = m.sleep || m.stop;
			end
			PSM_STOP_KEEP, PSM_STOP_FLT: begin
				r = m.stop;
			end
			default: begin
				r = 1'b0;
			end
		endcase
		return r;
	endfunction

	// Sleep or either stop state
	function automatic logic psm_is_low_power(input psm_state_t s);
		logic r;
		case (s)
			PSM_SLEEP, PSM_STOP_KEEP, PSM_STOP_FLT: begin
				r = 1'b1;
			end
			default: begin
				r = 1'b0;
			end
		endcase
		return r;
	endfunction

	// Live control: owning peripheral first, else port latch
	function automatic psm_pin_t psm_live_ctl(
		input logic own,
		input logic per_out,
		input logic per_oe,
		input logic lat_out,
		input logic lat_dir
	);
		psm_pin_t c;
		c.out = own ? per_out : lat_out;
		c.oe  = own ? per_oe : lat_dir;
		c.ie  = 1'b1;
		return c;
	endfunction

	// ---------------------------------------------------------------
	// Operating state sequencing
	// ---------------------------------------------------------------
	always_comb begin
		state_d = PSM_INIT_HELD;
		case (state_q)
			PSM_INIT_HELD: begin
				state_d = init_b ? PSM_INIT_REL : PSM_INIT_HELD;
			end
			PSM_INIT_REL: begin
				state_d = PSM_RUN;
			end
			PSM_RUN: begin
				state_d = psm_entry_state(mode);
			end
			PSM_SLEEP, PSM_STOP_KEEP, PSM_STOP_FLT: begin
				// Float select is only looked at on entry
				state_d = psm_still_req(state_q, mode) ? state_q : PSM_RUN;
			end
			default: begin
				state_d = PSM_INIT_HELD;
			end
		endcase
		// External reset pin wins from any state
		if (!init_b) begin
			state_d = PSM_INIT_HELD;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_q <= PSM_INIT_HELD;
		end else begin
			state_q <= state_d;
		end
	end

	// ---------------------------------------------------------------
	// Shared decode for all pins
	// ---------------------------------------------------------------
	// Pin controls are registered against the next state
	wire in_run     = (state_q == PSM_RUN);
	wire going_low  = psm_is_low_power(state_d);
	wire capture    = in_run && going_low; // see RQ9
	wire live_sel   = (state_d == PSM_RUN);
	wire float_cl   = (state_d == PSM_STOP_FLT); // see RQ1
	wire reset_held = (state_d == PSM_INIT_HELD);
	wire reset_rel  = (state_d == PSM_INIT_REL);

	assign state = state_q;

	// ---------------------------------------------------------------
	// Per-pin cells
	// ---------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < NPINS; i++) begin : g_pin
			psm_pin_t live;
			assign live = psm_live_ctl( // see RQ3
				periph_own[i],
				periph_out[i],
				periph_oe[i],
				port_out[i],
				port_dir[i]
			);
			psm_pin_cell u_cell (
				.clk        (clk),
				.rst_b      (rst_b),
				.capture    (capture),
				.live_sel   (live_sel),
				.float_cl   (float_cl),
				.wake_pin   (WAKE_MSK[i]),
				.nmi_pin    (NMI_MSK[i]),
				.reset_held (reset_held),
				.reset_rel  (reset_rel),
				.live       (live),
				.pad_in     (pad_in[i]),
				.ctl_q      (pin_ctl[i]),
				.core_in_q  (core_in[i])
			);
		end
	endgenerate
endmodule

// ==== rtl/psm_pkg.sv ====
// Constants and carrier types for the pin state controller.
// Assumes one synchronous clock domain; mode inputs come from the power controller.
package psm_pkg;

	// ---------------------------------------------------------------
	// Sizes and reset values
	// ---------------------------------------------------------------
	localparam int   PSM_NPINS      = 8;
	localparam logic PSM_RST_OE     = 1'b0;
	localparam logic PSM_RST_IE     = 1'b0;
	localparam logic PSM_RST_OUT    = 1'b0;
	localparam logic PSM_CLAMP_VAL  = 1'b0;

	// ---------------------------------------------------------------
	// Operating states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		PSM_INIT_HELD = 3'h0,
		PSM_INIT_REL  = 3'h1,
		PSM_RUN       = 3'h3,
		PSM_SLEEP     = 3'h2,
		PSM_STOP_KEEP = 3'h6,
		PSM_STOP_FLT  = 3'h7
	} psm_state_t;

	// Per-pin buffer control bundle
	typedef struct packed {
		logic out;
		logic oe;
		logic ie;
	} psm_pin_t;

	// Mode request bundle from the power controller
	typedef struct packed {
		logic sleep;
		logic stop;
		logic stop_float_select;
	} psm_mode_t;

endpackage

// ==== rtl/psm_pin_cell.sv ====
// One pin's buffer control: live path in run, frozen path in sleep and plain stop, float and clamp in float stop for pins that are neither wake nor NMI.
// Assumes the controller supplies a one-cycle capture strobe at mode entry.
`timescale 1ns/1ns
module psm_pin_cell (
	input  wire logic                clk,
	input  wire logic                rst_b,
	input  wire logic                capture,
	input  wire logic                live_sel,
	input  wire logic                float_cl,
	input  wire logic                wake_pin,
	input  wire logic                nmi_pin,
	input  wire logic                reset_held,
	input  wire logic                reset_rel,
	input  wire psm_pkg::psm_pin_t   live,
	input  wire logic                pad_in,
	output      psm_pkg::psm_pin_t   ctl_q,
	output      logic                core_in_q
);
	import psm_pkg::*;

	psm_pin_t held_q;
	psm_pin_t ctl_d;
	psm_pin_t kept;
	logic     core_in_d;
	wire      ie_on = ctl_d.ie;

	// ---------------------------------------------------------------
	// Frozen state at mode entry
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			held_q <= '{out: PSM_RST_OUT, oe: PSM_RST_OE, ie: PSM_RST_IE};
		end else if (capture) begin
			held_q <= live; // see RQ9
		end
	end

	// ---------------------------------------------------------------
	// Buffer control selection
	// ---------------------------------------------------------------
	// Entry edge shows live values, held_q loads on that same edge
	assign kept = capture ? live : held_q; // see RQ9

	always_comb begin
		if (reset_held) begin
			ctl_d = '{out: PSM_RST_OUT, oe: 1'b0, ie: nmi_pin}; // see RQ5
		end else if (reset_rel) begin
			ctl_d = '{out: PSM_RST_OUT, oe: 1'b0, ie: 1'b1}; // see RQ6
		end else if (live_sel) begin
			ctl_d = live;
		end else if (float_cl && !wake_pin && !nmi_pin) begin
			ctl_d = '{out: PSM_RST_OUT, oe: 1'b0, ie: 1'b0}; // see RQ1
		end else if (wake_pin || nmi_pin) begin
			ctl_d = '{out: kept.out, oe: kept.oe, ie: 1'b1}; // see RQ8
		end else begin
			ctl_d = kept; // see RQ2 see RQ4 see RQ7
		end
	end

	assign core_in_d = ie_on ? pad_in : PSM_CLAMP_VAL; // see RQ1

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctl_q     <= '{out: PSM_RST_OUT, oe: PSM_RST_OE, ie: nmi_pin}; // see RQ5
			core_in_q <= PSM_CLAMP_VAL;
		end else begin
			ctl_q     <= ctl_d;
			core_in_q <= core_in_d;
		end
	end
endmodule

// ==== tb/psm_sva.sv ====
// Port checks for the pin state controller.
// Assumes pin 0 is NMI, pin 1 wake, pins 2 to 7 ordinary.
`timescale 1ns/1ns
module psm_sva #(
	parameter int               NPINS    = 8,
	parameter logic [NPINS-1:0] WAKE_MSK = '0,
	parameter logic [NPINS-1:0] NMI_MSK  = '0
) (
	input wire logic                           clk,
	input wire logic                           rst_b,
	input wire logic                           init_b,
	input wire logic [NPINS-1:0]               periph_own,
	input wire logic [NPINS-1:0]               periph_out,
	input wire logic [NPINS-1:0]               port_out,
	input wire logic [NPINS-1:0]               port_dir,
	input wire psm_pkg::psm_pin_t [NPINS-1:0] pin_ctl,
	input wire logic [NPINS-1:0]               core_in,
	input wire psm_pkg::psm_state_t            state
);
	import psm_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence port_in_s;
		state == PSM_RUN && !periph_own[2] ##1 state inside {PSM_SLEEP, PSM_STOP_KEEP};
	endsequence
	sequence per_in_s;
		state == PSM_RUN && periph_own[4] ##1 state inside {PSM_SLEEP, PSM_STOP_KEEP};
	endsequence
	held_float_a: assert property (state == PSM_INIT_HELD |-> pin_ctl[2] == 3'h0 && pin_ctl[0].ie)
		else $error("held pins wrong");
	init_force_a: assert property (!init_b |=> state == PSM_INIT_HELD)
		else $error("init low not forced");
	rel_input_a: assert property (state == PSM_INIT_REL |-> !pin_ctl[2].oe && pin_ctl[2].ie)
		else $error("release pins wrong");
	float_clamp_a: assert property (state == PSM_STOP_FLT |-> pin_ctl[2] == 3'h0 && !core_in[2])
		else $error("float clamp wrong");
	wake_input_a: assert property (state[1] |-> pin_ctl[0].ie && pin_ctl[1].ie)
		else $error("wake input off");
	port_hold_a: assert property (port_in_s |-> pin_ctl[2].out == $past(port_out[2])
		&& pin_ctl[2].oe == $past(port_dir[2])) else $error("port hold wrong");
	per_hold_a: assert property (per_in_s |-> pin_ctl[4].out == $past(periph_out[4]))
		else $error("peripheral hold wrong");
	frozen_ctl_a: assert property (state inside {PSM_SLEEP, PSM_STOP_KEEP, PSM_STOP_FLT} && $past(state) == state
		|-> $stable(pin_ctl))
		else $error("retained state moved");
endmodule

// ==== tb/pin_state_by_cpu_mode_test.sv ====
// Directed bench for the pin state controller.
// Assumes psm_pkg and psm_ctrl are compiled first.
`timescale 1ns/1ns
module pin_state_by_cpu_mode_test;
	import psm_pkg::*;
	logic                 clk = 1'b0, rst_b = 1'b0, init_b = 1'b0;
	psm_mode_t            mode = '0;
	logic [7:0]           own = 8'h30, pout = 8'h10, poe = 8'h30, dout = 8'hA5, dir = 8'h0F, pad = 8'hFF;
	psm_pin_t [7:0]       pin_ctl;
	logic [7:0]           core_in;
	psm_state_t           state;
	int                   mismatches = 0, checked = 0;
	initial forever #20 clk = ~clk;
	psm_ctrl #(.NPINS(8), .WAKE_MSK(8'h02), .NMI_MSK(8'h01)) dut (.clk(clk), .rst_b(rst_b), .init_b(init_b),
		.mode(mode), .periph_own(own), .periph_out(pout), .periph_oe(poe), .port_out(dout), .port_dir(dir),
		.pad_in(pad), .pin_ctl(pin_ctl), .core_in(core_in), .state(state));
	function automatic logic [7:0] fld(int k);
		for (int i = 0; i < 8; i++) fld[i] = pin_ctl[i][k];
	endfunction
	task automatic chk(logic c, string m);
		checked++;
		if (c !== 1'b1) begin
			mismatches++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask
	task automatic t_init;
		chk(state === PSM_INIT_HELD && fld(1) === 8'h00 && fld(0) === 8'h01, "held");
		init_b = 1'b1;
		@(negedge clk);
		chk(state === PSM_INIT_REL && fld(1) === 8'h00 && fld(0) === 8'hFF, "release");
		@(negedge clk);
	endtask
	task automatic t_keep(psm_mode_t m, psm_state_t s);
		logic [7:0] eo, ed;
		eo = (own & pout) | (~own & dout);
		ed = (own & poe) | (~own & dir);
		mode = m;
		@(negedge clk);
		mode.stop_float_select = ~m.stop_float_select;
		dout = ~dout;
		dir = ~dir;
		pout = ~pout;
		pad = 8'h5C;
		repeat (2) @(negedge clk);
		chk(state === s && fld(2) === eo && fld(1) === ed && core_in === 8'h5C, "retain");
		mode = '0;
		repeat (2) @(negedge clk);
		chk(state === PSM_RUN && fld(2) === ((own & pout) | (~own & dout)), "live");
	endtask
	task automatic t_float;
		mode = 3'h3;
		@(negedge clk);
		mode = 3'h2;
		pad = 8'hFF;
		repeat (2) @(negedge clk);
		chk(state === PSM_STOP_FLT && fld(0) === 8'h03 && core_in === 8'h03, "float");
		chk((fld(1) & 8'hFC) === 8'h00 && (fld(2) & 8'hFC) === 8'h00, "float drive");
		mode = 3'h6;
		@(negedge clk);
		chk(state === PSM_STOP_FLT && core_in === 8'h03, "stop priority");
		init_b = 1'b0;
		@(negedge clk);
		chk(state === PSM_INIT_HELD && fld(1) === 8'h00 && fld(0) === 8'h01, "init in stop");
		mode = '0;
	endtask
	task automatic finish_test;
		if (mismatches == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		repeat (2) @(negedge clk);
		t_init;
		t_keep(3'h4, PSM_SLEEP);
		t_keep(3'h2, PSM_STOP_KEEP);
		t_float;
		t_init;
		finish_test;
	end
endmodule
bind psm_ctrl psm_sva #(.NPINS(NPINS), .WAKE_MSK(WAKE_MSK), .NMI_MSK(NMI_MSK)) sva_i (.clk(clk), .rst_b(rst_b),
	.init_b(init_b), .periph_own(periph_own), .periph_out(periph_out), .port_out(port_out),
	.port_dir(port_dir), .pin_ctl(pin_ctl), .core_in(core_in), .state(state));
